// *** hdl/terminal_bus_fault_indicator.sv ***
// Functional notes
// R01: red error LED dark without error
// R02: two blink rates, fast and slow
// R03: start burst, code pulses, pause, argument
// R04: LED off during the pause
// R05: argument counts modules before the fault
// R06: passive modules not counted
// R07: code three cmd error, four data break
// R08: five register error, six init/internal
// R09: seven for process data length mismatch
// R10: some errors persist until power cycle
// R11: green run LED only when fault-free
// R12: status zero only synchronous and error-free
// R13: status may be nonzero from slow cycle
// R14: host task period below 100 ms
// R15: status bits 0,1,2 bus/config/length
// R16: status bits 8,9,10 input/output state
// R17: status bit 11 watchdog, 15 acyclic
// R18: device reset clears error, restarts bus
// R19: sequence repeats while error stays indicated
// R20: rates derived by prescaler constants
//
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
module terminal_bus_fault_indicator
  import fault_ind_pkg::*;
#(
  parameter int FAST_CYC = FAST_HALF_CYC,  // shorten for simulation
  parameter int SLOW_CYC = SLOW_HALF_CYC   // shorten for simulation
)(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire errReport_s  errReport,   // from bus engine, same clock
  input  wire busCond_s    busCond,     // from bus engine, same clock
  input  wire logic        fieldbusOk,  // fieldbus communication running
  output logic             errLed,      // red error LED, high lights
  output logic             runLed,      // green run LED, high lights
  output logic             busRestart   // asks bus engine to restart
);

  // register slots returned by the address decoder
  localparam logic [2:0] IDX_STATUS  = 3'h0;
  localparam logic [2:0] IDX_CTRL    = 3'h1;
  localparam logic [2:0] IDX_ERRINFO = 3'h2;
  localparam logic [2:0] IDX_PASSIVE = 3'h3;
  localparam logic [2:0] IDX_NONE    = 3'h4;

  // address decode, shared by the read and write paths
  function automatic logic [2:0] regIndex(input logic [7:0] a);
    case (a)
      OFS_STATUS:  return IDX_STATUS;
      OFS_CTRL:    return IDX_CTRL;
      OFS_ERRINFO: return IDX_ERRINFO;
      OFS_PASSIVE: return IDX_PASSIVE;
      default:     return IDX_NONE;
    endcase
  endfunction : regIndex

  // write channel state
  logic        awHeld_ff;    // address taken, waiting for data
  logic [7:0]  awAddr_ff;
  logic        wHeld_ff;     // data taken, waiting for address
  logic [31:0] wData_ff;
  logic [3:0]  wStrb_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  // read channel state
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic [31:0] readMux;      // read data before registering
  // software state
  logic [15:0] passive_ff;   // passive slot mask
  logic [7:0]  rstCnt_ff;    // device reset in progress
  logic        rstBusy_ff;
  // error capture
  errReport_s  errPipe_ff;   // report aligned with its position
  logic        errLatched_ff;
  logic        sticky_ff;    // only a power cycle clears it
  logic [2:0]  errCode_ff;
  logic [4:0]  errArg_ff;
  logic        runLed_ff;
  // blink sequencer
  blink_e      state_ff;
  blink_e      nxt_state;
  logic [4:0]  cnt_ff;
  logic [4:0]  nxt_cnt;
  logic        led_ff;
  logic        nxt_led;
  logic [15:0] statusWord;
  logic [4:0]  posVal;
  logic        fastTick;
  logic        slowTick;

  // write path: address and data may arrive in either order
  wire        awTake   = awvalid && awready;
  wire        wTake    = wvalid && wready;
  wire        haveAw   = awHeld_ff || awTake;
  wire        haveW    = wHeld_ff || wTake;
  wire        doWrite  = haveAw && haveW && !bvalid_ff;
  wire [7:0]  wAddrNow = awHeld_ff ? awAddr_ff : awaddr;
  wire [31:0] wDataNow = wHeld_ff ? wData_ff : wdata;
  wire [3:0]  wStrbNow = wHeld_ff ? wStrb_ff : wstrb;
  wire [2:0]  wIdx     = regIndex(wAddrNow);
  wire [2:0]  rIdx     = regIndex(araddr);
  wire        arTake   = arvalid && arready;

  assign awready = !awHeld_ff && !bvalid_ff;
  assign wready  = !wHeld_ff && !bvalid_ff;
  assign arready = !rvalid_ff;

  // device reset function: a one written to the control bit
  wire devResetReq = doWrite && wIdx == IDX_CTRL && wStrbNow[0]
                     && wDataNow[CTRL_DEVRST_BIT];
  wire clearErr    = devResetReq && !sticky_ff;  // R18 R10

  // capture a new report; a report in the clearing cycle wins
  wire newErr = errPipe_ff.valid && (!errLatched_ff || clearErr);
  wire posArg = errPipe_ff.code == CODE_DATA || errPipe_ff.code == CODE_REG;
  wire [4:0] newArg = posArg ? posVal : {1'b0, errPipe_ff.detail};  // R07 R08 R09

  // write channel handshake registers
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      awHeld_ff <= 1'b0;
      awAddr_ff <= 8'h0;
      wHeld_ff  <= 1'b0;
      wData_ff  <= 32'h0;
      wStrb_ff  <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end
    else
    begin
      awHeld_ff <= doWrite ? 1'b0 : (awHeld_ff || awTake);
      wHeld_ff  <= doWrite ? 1'b0 : (wHeld_ff || wTake);
      if (awTake)
        awAddr_ff <= awaddr;
      if (wTake)
      begin
        wData_ff <= wdata;
        wStrb_ff <= wstrb;
      end
      // status and error info are read-only, writes answer okay
      if (doWrite)
      begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= (wIdx == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
      else if (bready)
        bvalid_ff <= 1'b0;
    end

  // read channel: data registered one cycle after the address
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0;
      rresp_ff  <= RESP_OKAY;
    end
    else if (arTake)
    begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= readMux;
      rresp_ff  <= (rIdx == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (rready)
      rvalid_ff <= 1'b0;

  // read data selection, reserved bits read zero
  always_comb
  begin
    readMux = 32'h0;
    case (rIdx)
      IDX_STATUS:  readMux[15:0] = statusWord;
      IDX_ERRINFO:
      begin
        readMux[EI_ARG_LSB +: 5]  = errArg_ff;
        readMux[EI_CODE_LSB +: 3] = errCode_ff;
        readMux[EI_LATCHED_BIT]   = errLatched_ff;
        readMux[EI_STICKY_BIT]    = sticky_ff;
      end
      IDX_PASSIVE: readMux[15:0] = passive_ff;
      default:     readMux = 32'h0;  // control reads zero
    endcase
  end

  // passive mask and device reset timer
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      passive_ff <= PASSIVE_RST;
      rstCnt_ff  <= 8'h0;
      rstBusy_ff <= 1'b0;
    end
    else
    begin
      if (doWrite && wIdx == IDX_PASSIVE && wStrbNow[0])
        passive_ff[7:0] <= wDataNow[7:0];
      if (doWrite && wIdx == IDX_PASSIVE && wStrbNow[1])
        passive_ff[15:8] <= wDataNow[15:8];
      // bus restart held for a fixed time after the request
      if (devResetReq)
        rstCnt_ff <= 8'(DEV_RESET_CYC);  // R18
      else if (rstCnt_ff != 8'h0)
        rstCnt_ff <= rstCnt_ff - 8'h1;
      rstBusy_ff <= devResetReq || rstCnt_ff > 8'h1;
    end

  // error latch; internal errors stay until the next power-on reset
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      errPipe_ff    <= '0;
      errLatched_ff <= 1'b0;
      sticky_ff     <= 1'b0;
      errCode_ff    <= 3'h0;
      errArg_ff     <= 5'h0;
    end
    else
    begin
      errPipe_ff <= errReport;
      if (newErr)
      begin
        errLatched_ff <= 1'b1;
        sticky_ff     <= errPipe_ff.code == CODE_INIT;  // R10
        errCode_ff    <= errPipe_ff.code;
        errArg_ff     <= newArg;  // R05
      end
      else if (clearErr)
        errLatched_ff <= 1'b0;  // R18
    end

  // status word; slow bus cycles alone can make it nonzero
  always_comb
  begin
    statusWord               = 16'h0;
    statusWord[ST_BUS_ERR]   = busCond.busErr || errLatched_ff;  // R15
    statusWord[ST_CFG_CHG]   = busCond.cfgChanged;  // R15
    statusWord[ST_LEN_MIS]   = busCond.lenMismatch;  // R15
    statusWord[ST_NO_INPUTS] = busCond.noValidInputs;  // R16
    statusWord[ST_IN_UPD]    = busCond.inUpdBusy;  // R16 R13
    statusWord[ST_OUT_UPD]   = busCond.outUpdBusy;  // R16 R13
    statusWord[ST_WDOG]      = busCond.watchdog;  // R17
    statusWord[ST_ACYCLIC]   = busCond.acyclicBusy || rstBusy_ff;  // R17
  end

  // green only with a clean status word and the fieldbus up
  always_ff @(posedge clk or posedge rst)
    if (rst)
      runLed_ff <= 1'b0;
    else
      runLed_ff <= fieldbusOk && statusWord == 16'h0;  // R11 R12

  // pulse-group bookkeeping: cnt counts completed pulses
  wire [4:0] cntInc    = cnt_ff + 5'h1;
  wire [4:0] target    = (state_ff == ST_ARG) ? errArg_ff : {2'h0, errCode_ff};
  wire       lastPulse = cntInc == target;

  // blink sequencer next state
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_led   = led_ff;
    case (state_ff)
      ST_IDLE:
      begin
        nxt_led = 1'b0;
        nxt_cnt = 5'h0;
        if (errLatched_ff)
          nxt_state = ST_START;  // R03
      end
      ST_START:
        if (fastTick)  // R02
        begin
          nxt_led = !led_ff;
          nxt_cnt = cntInc;
          if (cntInc == START_TOGGLES)
          begin
            nxt_state = ST_CODE;
            nxt_led   = 1'b0;
            nxt_cnt   = 5'h0;
          end
        end
      ST_CODE, ST_ARG:
        if (slowTick && led_ff)
        begin
          nxt_led = 1'b0;
          nxt_cnt = lastPulse ? 5'h0 : cntInc;
          if (lastPulse)
            nxt_state = (state_ff == ST_CODE) ? ST_PAUSE : ST_GAP;  // R03
        end
        else if (slowTick)
        begin
          // an argument of zero gives no pulses at all
          if (target == 5'h0)
            nxt_state = (state_ff == ST_CODE) ? ST_PAUSE : ST_GAP;  // R07
          else
            nxt_led = 1'b1;
        end
      ST_PAUSE, ST_GAP:
      begin
        nxt_led = 1'b0;  // R04
        if (slowTick)
        begin
          nxt_cnt = cntInc;
          if (state_ff == ST_PAUSE && cntInc == PAUSE_HALVES)
          begin
            nxt_state = ST_ARG;
            nxt_cnt   = 5'h0;
          end
          else if (state_ff == ST_GAP && cntInc == GAP_HALVES)
          begin
            nxt_state = ST_START;  // R19
            nxt_cnt   = 5'h0;
          end
        end
      end
      default:
      begin
        nxt_state = ST_IDLE;
        nxt_led   = 1'b0;
        nxt_cnt   = 5'h0;
      end
    endcase
    // a cleared error drops the sequence at once
    if (!errLatched_ff)
    begin
      nxt_state = ST_IDLE;  // R01
      nxt_led   = 1'b0;  // R01
      nxt_cnt   = 5'h0;
    end
  end

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      state_ff <= ST_IDLE;
      cnt_ff   <= 5'h0;
      led_ff   <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      led_ff   <= nxt_led;
    end

  blink_ticker #(
    .FAST_CYC (FAST_CYC),
    .SLOW_CYC (SLOW_CYC)
  ) u_ticker (
    .clk      (clk),
    .rst      (rst),
    .restart  (state_ff == ST_IDLE),
    .fastTick (fastTick),
    .slowTick (slowTick)
  );

  active_position u_position (
    .clk         (clk),
    .rst         (rst),
    .passiveMask (passive_ff),
    .lastSlot    (errReport.lastSlot),
    .position    (posVal)
  );

  assign bvalid     = bvalid_ff;
  assign bresp      = bresp_ff;
  assign rvalid     = rvalid_ff;
  assign rdata      = rdata_ff;
  assign rresp      = rresp_ff;
  assign errLed     = led_ff;
  assign runLed     = runLed_ff;
  assign busRestart = rstBusy_ff;

  // checks on the sequencer and status logic
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence idleWithErr;
    state_ff == ST_IDLE ##0 errLatched_ff;
  endsequence
  sequence codeDone;
    // a clear in flight sends the sequence to idle instead
    state_ff == ST_CODE && slowTick && led_ff && lastPulse && errLatched_ff;
  endsequence
  sequence resetReqClean;
    devResetReq && !sticky_ff && !errPipe_ff.valid;
  endsequence

  dark_no_error_a: assert property (!errLatched_ff |=> !errLed) // R01
    else $error("error LED lit without a latched error");
  start_marker_a: assert property (idleWithErr |=> state_ff == ST_START) // R03
    else $error("sequence did not open with the start burst");
  code_to_pause_a: assert property (codeDone |=> state_ff == ST_PAUSE && !errLed) // R03
    else $error("code group not followed by the pause");
  pause_dark_a: assert property (state_ff == ST_PAUSE |-> !errLed) // R04
    else $error("error LED lit during the pause");
  arg_position_a: assert property ( // R05
    errPipe_ff.valid && !errLatched_ff && errPipe_ff.code == CODE_DATA
    |=> errArg_ff == $past(posVal))
    else $error("argument is not the counted position");
  sticky_keep_a: assert property (sticky_ff && errLatched_ff |=> errLatched_ff) // R10
    else $error("power-cycle error was cleared");
  run_led_a: assert property (statusWord != 16'h0 |=> !runLed) // R11
    else $error("run LED lit with nonzero status");
  error_status_a: assert property (errLatched_ff |-> statusWord[ST_BUS_ERR]) // R12
    else $error("latched error not shown in status");
  dev_reset_a: assert property ( // R18
    resetReqClean |=> !errLatched_ff ##0 busRestart [*8])
    else $error("device reset did not clear and restart");
  acyclic_bit_a: assert property ( // R17
    devResetReq |=> busRestart && statusWord[ST_ACYCLIC])
    else $error("bus restart not flagged as acyclic");
  update_bits_a: assert property ( // R16
    busCond.inUpdBusy && busCond.outUpdBusy
    |-> statusWord[ST_IN_UPD] && statusWord[ST_OUT_UPD])
    else $error("update-incomplete bits missing");

endmodule : terminal_bus_fault_indicator
`default_nettype wire

// *** common/fault_ind_pkg.sv ***
package fault_ind_pkg;

  // clock and timing figures
  localparam int CLK_PERIOD_NS    = 10;        // 100 MHz system clock
  localparam int FAST_HALF_MS     = 50;        // fast blink half period
  localparam int SLOW_HALF_MS     = 250;       // slow pulse half period
  localparam int FAST_HALF_CYC    = FAST_HALF_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SLOW_HALF_CYC    = SLOW_HALF_MS * 1000000 / CLK_PERIOD_NS;
  localparam int DEV_RESET_NS     = 1000;      // bus restart request length
  localparam int DEV_RESET_CYC    = DEV_RESET_NS / CLK_PERIOD_NS;

  // sequence shape, counted in half periods of the matching rate
  localparam logic [4:0] START_TOGGLES = 5'h10;  // eight fast blinks
  localparam logic [4:0] PAUSE_HALVES  = 5'h04;  // dark pause, slow halves
  localparam logic [4:0] GAP_HALVES    = 5'h06;  // dark gap before repeat

  // register byte offsets
  localparam logic [7:0] OFS_STATUS  = 8'h00;
  localparam logic [7:0] OFS_CTRL    = 8'h04;
  localparam logic [7:0] OFS_ERRINFO = 8'h08;
  localparam logic [7:0] OFS_PASSIVE = 8'h0c;

  // status word bit positions
  localparam int ST_BUS_ERR   = 0;
  localparam int ST_CFG_CHG   = 1;
  localparam int ST_LEN_MIS   = 2;
  localparam int ST_NO_INPUTS = 8;
  localparam int ST_IN_UPD    = 9;
  localparam int ST_OUT_UPD   = 10;
  localparam int ST_WDOG      = 11;
  localparam int ST_ACYCLIC   = 15;

  // control and error-info fields
  localparam int CTRL_DEVRST_BIT = 0;
  localparam int EI_LATCHED_BIT  = 16;
  localparam int EI_STICKY_BIT   = 17;
  localparam int EI_CODE_LSB     = 8;
  localparam int EI_ARG_LSB      = 0;

  // error codes as pulse counts
  localparam logic [2:0] CODE_CMD  = 3'h3;
  localparam logic [2:0] CODE_DATA = 3'h4;
  localparam logic [2:0] CODE_REG  = 3'h5;
  localparam logic [2:0] CODE_INIT = 3'h6;
  localparam logic [2:0] CODE_LEN  = 3'h7;

  localparam int         NUM_SLOTS    = 16;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
  localparam logic [15:0] PASSIVE_RST = 16'h0000;

  // error report from the bus engine
  typedef struct packed {
    logic       valid;     // one-cycle pulse
    logic [2:0] code;      // pulse count of the error code
    logic [4:0] lastSlot;  // physical slots before the fault location
    logic [3:0] detail;    // argument for codes without position
  } errReport_s;

  // running bus conditions from the bus engine
  typedef struct packed {
    logic busErr;
    logic cfgChanged;
    logic lenMismatch;
    logic noValidInputs;
    logic inUpdBusy;
    logic outUpdBusy;
    logic watchdog;
    logic acyclicBusy;
  } busCond_s;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_START = 3'h1,
    ST_CODE  = 3'h3,
    ST_PAUSE = 3'h2,
    ST_ARG   = 3'h6,
    ST_GAP   = 3'h7
  } blink_e;

endpackage : fault_ind_pkg

// *** hdl/blink_ticker.sv ***
`timescale 1ns/100ps
`default_nettype none
module blink_ticker
  import fault_ind_pkg::*;
#(
  parameter int FAST_CYC = FAST_HALF_CYC,
  parameter int SLOW_CYC = SLOW_HALF_CYC
)(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic restart,   // hold counters at zero
  output logic      fastTick,  // one pulse per fast half period
  output logic      slowTick   // one pulse per slow half period
);

  logic [31:0] fastCnt_ff;   // fast prescaler
  logic [31:0] slowCnt_ff;   // slow prescaler
  logic        fastTick_ff;
  logic        slowTick_ff;

  // both rates from the system clock by plain prescalers
  wire fastWrap = fastCnt_ff == 32'(FAST_CYC - 1);  // R20
  wire slowWrap = slowCnt_ff == 32'(SLOW_CYC - 1);  // R20

  // prescalers restart in idle so a sequence started from idle begins on a full half period
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      fastCnt_ff  <= 32'h0;
      slowCnt_ff  <= 32'h0;
      fastTick_ff <= 1'b0;
      slowTick_ff <= 1'b0;
    end
    else
    begin
      fastCnt_ff  <= (restart || fastWrap) ? 32'h0 : fastCnt_ff + 32'h1;
      slowCnt_ff  <= (restart || slowWrap) ? 32'h0 : slowCnt_ff + 32'h1;
      fastTick_ff <= !restart && fastWrap;  // R02
      slowTick_ff <= !restart && slowWrap;  // R02
    end

  assign fastTick = fastTick_ff;
  assign slowTick = slowTick_ff;

endmodule : blink_ticker
`default_nettype wire

// *** hdl/active_position.sv ***
`timescale 1ns/100ps
`default_nettype none
module active_position
  import fault_ind_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic [NUM_SLOTS-1:0] passiveMask,  // 1 marks a passive slot
  input  wire logic [4:0]           lastSlot,     // slots before the fault
  output logic      [4:0]           position      // active modules counted
);

  logic [NUM_SLOTS-1:0] activeBelow;  // active slots ahead of the fault
  logic [4:0]           pos_ff;

  // population count of a slot vector
  function automatic logic [4:0] countOnes(input logic [NUM_SLOTS-1:0] v);
    logic [4:0] n;
    n = 5'h0;
    for (int k = 0; k < NUM_SLOTS; k++)
      n = n + {4'h0, v[k]};
    return n;
  endfunction : countOnes

  // passive modules such as power feeds are left out of the count
  genvar i;
  generate
    for (i = 0; i < NUM_SLOTS; i++)
    begin : g_slot
      assign activeBelow[i] = (5'(i) < lastSlot) && !passiveMask[i];  // R06
    end
  endgenerate

  // registered, one cycle behind lastSlot
  always_ff @(posedge clk or posedge rst)
    if (rst)
      pos_ff <= 5'h0;
    else
      pos_ff <= countOnes(activeBelow);  // R05

  assign position = pos_ff;

endmodule : active_position
`default_nettype wire

// *** verif/term_chain_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// stands for the bus engine and the chain of modules behind it
module term_chain_model
  import fault_ind_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       busRestart,  // restart asked by the device
  input  wire logic       fire,        // one report wanted
  input  wire errReport_s req,         // report contents
  input  wire busCond_s   cond,        // conditions wanted
  output var  errReport_s errReport,   // report pulse to the device
  output var  busCond_s   busCond      // running conditions
);
  // a report lives one cycle only, as the engine raises it
  always_ff @(posedge clk)
  begin
    errReport <= fire ? req : '0;
  end
  // a restart drops only the bus error, the other conditions pass through
  always_comb
  begin
    busCond = cond;
    if (busRestart)
      busCond.busErr = 1'b0;
  end
endmodule : term_chain_model
`default_nettype wire

// *** verif/terminal_bus_fault_indicator_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module terminal_bus_fault_indicator_bench;
  import fault_ind_pkg::*;
  localparam int FC = 4;   // short fast half period
  localparam int SC = 10;  // short slow half period
  logic        clk = 0, rst = 1, fire = 0, fieldbusOk = 0, watchLed = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0]  wstrb = 4'hf;  // whole words only
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        errLed, runLed, busRestart;
  errReport_s  req = '0, errReport;
  busCond_s    cond = '0, busCond, c;
  logic [33:0] expQ[$];    // response code and read data awaited
  int          pulseQ[$];  // low width times 256 plus high width
  int          miscompares = 0, checked = 0, cycles = 0;
  int          hi = 0, lo = 0, lastLo = 0, e;
  terminal_bus_fault_indicator #(.FAST_CYC(FC), .SLOW_CYC(SC)) DUT (
    .clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .errReport(errReport), .busCond(busCond), .fieldbusOk(fieldbusOk),
    .errLed(errLed), .runLed(runLed), .busRestart(busRestart));
  term_chain_model chain (.clk(clk), .busRestart(busRestart), .fire(fire),
    .req(req), .cond(cond), .errReport(errReport), .busCond(busCond));
  always #5 clk = ~clk;
  task automatic compare(input logic [33:0] got, input logic [33:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : compare
  task automatic end_of_test();
    if (miscompares == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test
  // each channel is released at its own handshake edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    expQ.push_back({r, 32'h0});
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    fork
      begin
        @(posedge clk iff awready);
        awvalid <= 0;
      end
      begin
        @(posedge clk iff wready);
        wvalid <= 0;
      end
    join
    @(posedge clk iff bvalid);
    bready <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [33:0] x);
    expQ.push_back(x);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    @(posedge clk iff arready);
    arvalid <= 0;
    @(posedge clk iff rvalid);
    rready <= 0;
  endtask : rd
  task automatic report(input logic [2:0] k, input logic [4:0] s,
                        input logic [3:0] d);
    @(posedge clk);
    req <= '{1'b1, k, s, d};
    fire <= 1;
    @(posedge clk);
    fire <= 0;
    repeat (3) @(posedge clk);
  endtask : report
  // latch, read back, then ask for the device reset
  task automatic errCase(input logic [2:0] k, input logic [4:0] s,
                         input logic [3:0] d, input logic [31:0] x);
    report(k, s, d);
    rd(OFS_ERRINFO, {RESP_OKAY, x});
    wr(OFS_CTRL, 32'h1, RESP_OKAY);
    repeat (110) @(posedge clk);
  endtask : errCase
  // bus answers and led pulses are judged against the oldest note
  // sampled on the falling edge, where every output has settled
  always @(negedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      end_of_test();
    end
    if (bvalid && bready)
      compare({bresp, 32'h0}, expQ.pop_front());
    if (rvalid && rready)
      compare({rresp, rdata}, expQ.pop_front());
    if (errLed)
    begin
      if (hi == 0)
        lastLo = lo;
      hi++;
      lo = 0;
    end
    else
    begin
      // a pulse with no note pending is an unwanted blink
      if (hi > 0 && watchLed)
      begin
        e = pulseQ.size() ? pulseQ.pop_front() : 0;
        compare(e / 256 ? lastLo * 256 + hi : hi, e);
      end
      hi = 0;
      lo++;
    end
  end
  initial
  begin
    void'($urandom(81));
    repeat (3) @(posedge clk);
    rst <= 0;
    watchLed <= 1;
    fieldbusOk <= 1;
    rd(OFS_STATUS, {RESP_OKAY, 32'h0});
    compare(runLed, 1);
    // random conditions must land on their own status bits
    repeat (8)
    begin
      c = busCond_s'(8'($urandom));
      cond <= c;
      repeat (2) @(posedge clk);
      rd(OFS_STATUS, {RESP_OKAY, 16'h0, c.acyclicBusy, 3'h0, c.watchdog,
         c.outUpdBusy, c.inUpdBusy, c.noValidInputs, 5'h0, c.lenMismatch,
         c.cfgChanged, c.busErr});
      compare(runLed, c == 0);
    end
    cond <= '0;
    wr(OFS_PASSIVE, 32'h2, RESP_OKAY);
    rd(OFS_PASSIVE, {RESP_OKAY, 32'h2});
    wr(8'h10, 32'h1, RESP_SLVERR);
    rd(8'h10, {RESP_SLVERR, 32'h0});
    // two whole sequences: start burst, five code, pause, two arg
    repeat (2)
    begin
      repeat (8) pulseQ.push_back(FC);
      repeat (5) pulseQ.push_back(SC);
      pulseQ.push_back(5 * SC * 256 + SC);
      pulseQ.push_back(SC);
    end
    report(CODE_REG, 5'h3, 4'h0);
    rd(OFS_ERRINFO, {RESP_OKAY, 32'h10502});
    wait (pulseQ.size() == 0);
    wr(OFS_CTRL, 32'h1, RESP_OKAY);
    compare(busRestart, 1);
    rd(OFS_STATUS, {RESP_OKAY, 32'h8000});
    rd(OFS_ERRINFO, {RESP_OKAY, 32'h502});
    repeat (200) @(posedge clk);
    compare(busRestart, 0);
    watchLed <= 0;
    errCase(CODE_CMD, 5'h0, 4'h0, 32'h10300);
    errCase(CODE_DATA, 5'h4, 4'h0, 32'h10403);
    errCase(CODE_LEN, 5'h0, 4'h0, 32'h10700);
    errCase(CODE_INIT, 5'h0, 4'h8, 32'h30608);
    report(CODE_REG, 5'h3, 4'h0);
    rd(OFS_ERRINFO, {RESP_OKAY, 32'h30608});
    rst <= 1;
    repeat (3) @(posedge clk);
    rst <= 0;
    rd(OFS_ERRINFO, {RESP_OKAY, 32'h0});
    rd(OFS_PASSIVE, {RESP_OKAY, 32'h0});
    compare(errLed, 0);
    end_of_test();
  end
endmodule : terminal_bus_fault_indicator_bench
`default_nettype wire
